// ---- inc/video_pkg.sv ----
// Shared constants, types and helpers for the bitplane video serializer
`default_nettype none

package video_pkg;

  // Register byte offsets on the APB
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_BASE   = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_FETCH  = 12'h00c;
  localparam logic [11:0] ADDR_PAL    = 12'h040;
  localparam logic [5:0]  PAL_PAGE    = 6'h01;

  // Values after reset
  localparam logic [1:0]  CTRL_RST = 2'h0;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [14:0] OFS_RST  = 15'h0000;

  // Status bit positions
  localparam int unsigned ST_MONO   = 0;
  localparam int unsigned ST_LINE   = 1;
  localparam int unsigned ST_LOADED = 2;

  // Field positions
  localparam int unsigned BASE_LSB = 8;
  localparam int unsigned BASE_MSB = 23;
  localparam int unsigned RGB_MSB  = 8;

  // Geometry of display memory and the shifter
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned MAX_PLANES  = 4;
  localparam int unsigned PAL_ENTRIES = 16;
  localparam int unsigned OFS_BITS    = 15;
  localparam logic [14:0] WORD_STEP   = 15'h0002;
  localparam logic [3:0]  LAST_BIT    = 4'hf;

  typedef enum logic [1:0] {
    RES_LOW  = 2'h0,
    RES_MED  = 2'h1,
    RES_HIGH = 2'h2
  } res_t;

  typedef enum logic [1:0] {
    FETCH_IDLE = 2'h0,
    FETCH_REQ  = 2'h1,
    FETCH_LOAD = 2'h3
  } fetch_state_t;

  typedef struct packed {
    logic [2:0] red;
    logic [2:0] green;
    logic [2:0] blue;
  } rgb_t;

  typedef struct packed {
    logic vsync;
    logic hsync;
    logic line_active;
    logic video_blanking;
    logic mono_monitor_detect_n;
  } timing_t;

  // Planes per interleaved group; code 3 behaves as high resolution
  function automatic logic [2:0] planes_of(input logic [1:0] res);
    case (res)
      RES_LOW: return 3'h4;
      RES_MED: return 3'h2;
      default: return 3'h1;
    endcase
  endfunction

  function automatic logic is_mono(input logic [1:0] res);
    return res[1];
  endfunction

endpackage

`default_nettype wire

// ---- hw/sync_bits.sv ----
// Two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ns
`default_nettype none

module sync_bits #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// ---- hw/display_fetch.sv ----
// Display memory fetch: address counter and word request handshake
`timescale 1ns/1ns
`default_nettype none

module display_fetch
  import video_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        vsync,
  input  wire logic        line_active,
  input  wire logic        fetch_en,
  input  wire logic [15:0] base,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_data,
  output var  logic        mem_req,
  output var  logic [23:0] mem_addr,
  output var  logic        load_strobe,
  output var  logic [15:0] load_word
);

  fetch_state_t          state;
  logic [OFS_BITS-1:0]   offset;

  // Offset inside the 32 KB frame; vertical sync wins over an advance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset <= OFS_RST;
    end else if (vsync) begin
      offset <= OFS_RST;
    end else if (state == FETCH_REQ && mem_ack) begin
      offset <= offset + WORD_STEP;
    end
  end

  // One outstanding read; the extra LOAD cycle lets the stage count settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= FETCH_IDLE;
      mem_req     <= 1'b0;
      mem_addr    <= 24'h000000;
      load_strobe <= 1'b0;
      load_word   <= 16'h0000;
    end else begin
      unique case (state)
        FETCH_IDLE: begin
          if (line_active && fetch_en && !vsync) begin
            state    <= FETCH_REQ;
            mem_req  <= 1'b1;
            mem_addr <= {base, 8'h00} + {9'h000, offset};
          end
        end
        FETCH_REQ: begin
          if (mem_ack) begin
            state       <= FETCH_LOAD;
            mem_req     <= 1'b0;
            load_strobe <= 1'b1;
            load_word   <= mem_data;
          end
        end
        FETCH_LOAD: begin
          state       <= FETCH_IDLE;
          load_strobe <= 1'b0;
        end
      endcase
    end
  end

  property p_strobe_after_ack;
    @(posedge pclk) disable iff (!presetn)
      load_strobe |-> $past(mem_ack) && $past(mem_req) && !mem_req;
  endproperty
  a_strobe_after_ack: assert property (p_strobe_after_ack)
    else $error("load strobe without a completed memory read");

  property p_vsync_reload;
    @(posedge pclk) disable iff (!presetn)
      vsync |=> offset == OFS_RST;
  endproperty
  a_vsync_reload: assert property (p_vsync_reload)
    else $error("fetch offset not reloaded after vertical sync");

  property p_req_on_line;
    @(posedge pclk) disable iff (!presetn)
      $rose(mem_req) |-> $past(line_active) && $past(fetch_en);
  endproperty
  a_req_on_line: assert property (p_req_on_line)
    else $error("memory read started outside a display line");

endmodule

`default_nettype wire

// ---- hw/bitplane_video_serializer.sv ----
// Bitplane video path: APB registers, palette, plane serializer, pin outputs
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none

module bitplane_video_serializer
  import video_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        vsync_in,
  input  wire logic        hsync_in,
  input  wire logic        line_active,
  input  wire logic        video_blanking,
  input  wire logic        mono_monitor_detect_n,
  output var  logic        mem_req,
  output var  logic [23:0] mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_data,
  output var  logic        shifter_load_strobe,
  output var  logic        palette_select,
  output var  rgb_t        rgb_out,
  output var  logic        mono_out,
  output var  logic        monitor_hsync,
  output var  logic        monitor_vsync,
  output var  logic        mod_hsync,
  output var  logic        mod_vsync,
  output var  logic        irq_mono_detect,
  output var  logic        irq_line_start
);

  timing_t      timing_raw;
  timing_t      timing_s;
  logic         vsync_s;
  logic         hsync_s;
  logic         line_s;
  logic         blank_s;
  logic         mono_n_s;
  logic [1:0]   mode;
  logic [15:0]  base;
  rgb_t         palette [PAL_ENTRIES];
  logic         access;
  logic         commit;
  logic [31:0]  read_word;
  logic [15:0]  load_word;
  logic [15:0]  stage [MAX_PLANES];
  logic [15:0]  shift [MAX_PLANES];
  logic [2:0]   stage_cnt;
  logic [2:0]   planes;
  logic         stage_full;
  logic         fetch_en;
  logic         shift_valid;
  logic [3:0]   bit_pos;
  logic         pix_div;
  logic         pix_tick;
  logic         transfer;
  logic         loaded_once;
  logic         show;
  logic         pix_mono;
  logic [3:0]   pix_index;
  logic         line_q;

  function automatic logic pal_hit(input logic [11:0] addr);
    return (addr[11:6] == PAL_PAGE) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic reg_hit(input logic [11:0] addr);
    return pal_hit(addr) || (addr == ADDR_CTRL) || (addr == ADDR_BASE) ||
           (addr == ADDR_STATUS) || (addr == ADDR_FETCH);
  endfunction

  // Timing controller pins are asynchronous here, so resynchronise them
  assign timing_raw = '{vsync: vsync_in, hsync: hsync_in, line_active: line_active,
                        video_blanking: video_blanking,
                        mono_monitor_detect_n: mono_monitor_detect_n};

  sync_bits #(
    .WIDTH (5)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (timing_raw),
    .q       (timing_s)
  );

  assign vsync_s  = timing_s.vsync;
  assign hsync_s  = timing_s.hsync;
  assign line_s   = timing_s.line_active;
  assign blank_s  = timing_s.video_blanking;
  assign mono_n_s = timing_s.mono_monitor_detect_n;

  // APB: one wait state, writes land on the edge that sees pready
  assign access = psel & penable & ~pready;
  assign commit = psel & penable & pready & pwrite;

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    read_word = 32'h0000_0000;
    if (pal_hit(paddr)) begin
      read_word[RGB_MSB:0] = palette[paddr[5:2]];
    end else begin
      case (paddr)
        ADDR_CTRL:   read_word[1:0] = mode;
        ADDR_BASE:   read_word[BASE_MSB:BASE_LSB] = base;
        ADDR_STATUS: begin
          read_word[ST_MONO]   = ~mono_n_s;
          read_word[ST_LINE]   = line_s;
          read_word[ST_LOADED] = loaded_once;
        end
        ADDR_FETCH:  read_word[23:0] = mem_addr;
        default:     read_word = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & ~reg_hit(paddr);
      prdata  <= (access & ~pwrite) ? read_word : 32'h0000_0000;
    end
  end

  // Control and base address; the base keeps only 256-byte granules
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= CTRL_RST;
      base <= BASE_RST;
    end else begin
      if (commit && paddr == ADDR_CTRL) begin
        mode <= pwdata[1:0];
      end
      if (commit && paddr == ADDR_BASE) begin
        base <= pwdata[BASE_MSB:BASE_LSB];
      end
    end
  end

  // Palette storage, nine bits per entry
  // sixteen palette entries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PAL_ENTRIES; i++) begin
        palette[i] <= '0;
      end
    end else if (commit && pal_hit(paddr)) begin
      palette[paddr[5:2]] <= rgb_t'(pwdata[RGB_MSB:0]);
    end
  end

  // Colour map select rides with the completing cycle of a palette write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      palette_select <= 1'b0;
    end else begin
      palette_select <= access & pwrite & pal_hit(paddr);
    end
  end

  assign planes     = planes_of(mode);
  assign stage_full = (stage_cnt == planes);
  assign fetch_en   = line_s & ~stage_full;

  display_fetch u_fetch (
    .pclk        (pclk),
    .presetn     (presetn),
    .vsync       (vsync_s),
    .line_active (line_s),
    .fetch_en    (fetch_en),
    .base        (base),
    .mem_ack     (mem_ack),
    .mem_data    (mem_data),
    .mem_req     (mem_req),
    .mem_addr    (mem_addr),
    .load_strobe (shifter_load_strobe),
    .load_word   (load_word)
  );

  // Low resolution runs at half the pixel rate of the other modes
  assign pix_tick = (mode == RES_LOW) ? pix_div : 1'b1;
  assign transfer = stage_full & (~shift_valid | (pix_tick & (bit_pos == LAST_BIT)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_div <= 1'b0;
    end else begin
      pix_div <= line_s & ~pix_div;
    end
  end

  // Staging words of one interleaved group; a late word off-line is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_cnt <= 3'h0;
      for (int i = 0; i < MAX_PLANES; i++) begin
        stage[i] <= 16'h0000;
      end
    end else if (!line_s || transfer) begin
      stage_cnt <= 3'h0;
    end else if (shifter_load_strobe) begin
      stage[stage_cnt[1:0]] <= load_word;
      stage_cnt             <= stage_cnt + 3'h1;
    end
  end

  // Plane shift registers; unused planes shift in zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_valid <= 1'b0;
      bit_pos     <= 4'h0;
      for (int i = 0; i < MAX_PLANES; i++) begin
        shift[i] <= 16'h0000;
      end
    end else if (!line_s) begin
      shift_valid <= 1'b0;
      bit_pos     <= 4'h0;
    end else if (transfer) begin
      shift_valid <= 1'b1;
      bit_pos     <= 4'h0;
      for (int i = 0; i < MAX_PLANES; i++) begin
        shift[i] <= (3'(i) < planes) ? stage[i] : 16'h0000;
      end
    end else if (shift_valid && pix_tick) begin
      bit_pos <= bit_pos + 4'h1;
      if (bit_pos == LAST_BIT) begin
        shift_valid <= 1'b0;
      end
      for (int i = 0; i < MAX_PLANES; i++) begin
        shift[i] <= shift[i] >> 1;
      end
    end
  end

  // First load releases the outputs; it never falls again until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_once <= 1'b0;
    end else if (shifter_load_strobe) begin
      loaded_once <= 1'b1;
    end
  end

  assign pix_index = {shift[3][0], shift[2][0], shift[1][0], shift[0][0]};
  assign pix_mono  = shift[0][0] ^ palette[0].blue[0];
  assign show      = shift_valid & ~blank_s & loaded_once;

  // Pixel outputs, registered so the pins never glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rgb_out  <= '0;
      mono_out <= 1'b0;
    end else begin
      rgb_out  <= (show & ~is_mono(mode)) ? palette[pix_index] : '0;
      mono_out <= show & is_mono(mode) & pix_mono;
    end
  end

  // Sync and interrupt source outputs, one register behind the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_hsync   <= 1'b0;
      monitor_vsync   <= 1'b0;
      mod_hsync       <= 1'b0;
      mod_vsync       <= 1'b0;
      line_q          <= 1'b0;
      irq_line_start  <= 1'b0;
      irq_mono_detect <= 1'b0;
    end else begin
      monitor_hsync   <= hsync_s;
      monitor_vsync   <= vsync_s;
      mod_hsync       <= hsync_s;
      mod_vsync       <= vsync_s;
      line_q          <= line_s;
      irq_line_start  <= line_s & ~line_q;
      irq_mono_detect <= ~mono_n_s;
    end
  end

  property p_palette_select;
    @(posedge pclk) disable iff (!presetn)
      palette_select |-> pready && pwrite && pal_hit(paddr);
  endproperty
  a_palette_select: assert property (p_palette_select)
    else $error("palette select outside a palette write");

  property p_blank_dark;
    @(posedge pclk) disable iff (!presetn)
      blank_s |=> (rgb_out == '0) && !mono_out;
  endproperty
  a_blank_dark: assert property (p_blank_dark)
    else $error("video output active during blanking");

  property p_mono_bypass;
    @(posedge pclk) disable iff (!presetn)
      is_mono(mode) |=> rgb_out == '0;
  endproperty
  a_mono_bypass: assert property (p_mono_bypass)
    else $error("colour outputs driven in monochrome mode");

  property p_mono_inverse;
    @(posedge pclk) disable iff (!presetn)
      show && is_mono(mode) |=> mono_out == $past(pix_mono);
  endproperty
  a_mono_inverse: assert property (p_mono_inverse)
    else $error("mono pixel does not follow palette entry zero bit 0");

  property p_base_aligned;
    @(posedge pclk) disable iff (!presetn)
      pready && !pwrite && (paddr == ADDR_BASE) |-> prdata[7:0] == 8'h00;
  endproperty
  a_base_aligned: assert property (p_base_aligned)
    else $error("base address reads back off a 256-byte boundary");

  property p_bit_advance;
    @(posedge pclk) disable iff (!presetn)
      line_s && shift_valid && pix_tick && !transfer && (bit_pos != LAST_BIT)
        |=> (bit_pos == $past(bit_pos) + 4'h1) && shift_valid;
  endproperty
  a_bit_advance: assert property (p_bit_advance)
    else $error("bit position did not advance by one");

  property p_low_group;
    @(posedge pclk) disable iff (!presetn)
      transfer && (mode == RES_LOW) |-> stage_cnt == 3'h4;
  endproperty
  a_low_group: assert property (p_low_group)
    else $error("low resolution group moved without four words");

  property p_dark_before_load;
    @(posedge pclk) disable iff (!presetn)
      !loaded_once |-> (rgb_out == '0) && !mono_out;
  endproperty
  a_dark_before_load: assert property (p_dark_before_load)
    else $error("outputs lit before the first display word");

  property p_line_start;
    @(posedge pclk) disable iff (!presetn)
      line_s && !line_q |=> irq_line_start ##1 !irq_line_start;
  endproperty
  a_line_start: assert property (p_line_start)
    else $error("line start source not a single pulse");

  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("APB access not answered after one wait state");

endmodule

`default_nettype wire

// ---- verif/display_mem_model.sv ----
// Display memory partner answering word fetches from the serializer
`timescale 1ns/1ns
`default_nettype none

module display_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_addr,
  input  wire logic [3:0]  latency,
  input  wire logic [3:0]  plane_mask,
  output var  logic        mem_ack,
  output var  logic [15:0] mem_data
);
  logic       busy;
  logic [3:0] cnt;

  // interleaved plane words
  // Plane of a word follows its address; released data is inverted so stale reads show
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack  <= 1'b0;
      mem_data <= 16'h0000;
      busy     <= 1'b0;
      cnt      <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_ack)
        mem_data <= ~mem_data;
      if (mem_req && !busy && !mem_ack) begin
        busy <= 1'b1;
        cnt  <= latency;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy     <= 1'b0;
        mem_ack  <= 1'b1;
        mem_data <= plane_mask[mem_addr[2:1]] ? 16'hffff : 16'h0000;
      end
    end
  end
endmodule

`default_nettype wire

// ---- verif/bitplane_video_serializer_test.sv ----
// Self-checking bench for the bitplane video serializer
`timescale 1ns/1ns
`default_nettype none

module bitplane_video_serializer_test
  import video_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ps;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, b;
  logic        vsync_in, hsync_in, line_active, video_blanking, mono_monitor_detect_n;
  logic        mem_req, mem_ack, shifter_load_strobe, palette_select, mono_out;
  logic        monitor_hsync, monitor_vsync, mod_hsync, mod_vsync;
  logic        irq_mono_detect, irq_line_start;
  logic [23:0] mem_addr;
  logic [15:0] mem_data;
  logic [3:0]  latency, plane_mask, m;
  logic [2:0]  ev;
  rgb_t        rgb_out;
  logic [8:0]  pal [PAL_ENTRIES];
  int          error_cnt = 0;
  int          samples_checked = 0;

  assign ev = {irq_line_start, mem_ack, mem_req};

  bitplane_video_serializer bitplane_video_serializer_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .vsync_in, .hsync_in, .line_active, .video_blanking,
    .mono_monitor_detect_n, .mem_req, .mem_addr, .mem_ack, .mem_data,
    .shifter_load_strobe, .palette_select, .rgb_out, .mono_out, .monitor_hsync,
    .monitor_vsync, .mod_hsync, .mod_vsync, .irq_mono_detect, .irq_line_start
  );

  display_mem_model display_mem_model_inst (
    .pclk, .presetn, .mem_req, .mem_addr, .latency, .plane_mask, .mem_ack, .mem_data
  );

  // Free-running pixel clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the release is followed by an idle edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) error_cnt++;
    q       = prdata;
    err     = pslverr;
    ps      = palette_select;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Bounded wait on a design event line
  task automatic wait_hi(input int i);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ev[i] !== 1'b1 && n < 200);
    if (n >= 200) error_cnt++;
  endtask

  // Restart a line; a frame sync after the last read realigns words to plane 0
  task automatic run_line(input logic [3:0] mk);
    line_active <= 1'b0;
    repeat (16) @(posedge pclk);
    vsync_in    <= 1'b1;
    repeat (4) @(posedge pclk);
    vsync_in    <= 1'b0;
    repeat (4) @(posedge pclk);
    plane_mask  <= mk;
    line_active <= 1'b1;
    wait_hi(2);
    repeat (120) @(posedge pclk);
  endtask

  function automatic logic [31:0] exp_rgb(input logic [1:0] res, input logic [3:0] mk);
    logic [3:0] idx;
    idx = (res == RES_LOW) ? mk : {2'b00, mk[1:0]};
    return {23'h0, pal[idx]};
  endfunction

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog: far beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    end_of_test();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h63e8));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {vsync_in, hsync_in, line_active, video_blanking} = '0;
    mono_monitor_detect_n = 1'b1;
    latency = 4'h0;
    plane_mask = 4'h0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({23'h0, rgb_out}, 32'h0);
    chk({31'h0, mono_out}, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(q, {30'h0, CTRL_RST});
    apb(1'b0, ADDR_BASE, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, err}, 32'h1);
    b = $urandom;
    apb(1'b1, ADDR_BASE, b);
    chk({31'h0, ps}, 32'h0);
    apb(1'b0, ADDR_BASE, 32'h0);
    chk(q, b & 32'h00ffff00);
    for (int i = 0; i < PAL_ENTRIES; i++) begin
      pal[i] = 9'($urandom);
      apb(1'b1, ADDR_PAL + 12'(4 * i), {23'h0, pal[i]});
      chk({31'h0, ps}, 32'h1);
    end
    for (int i = 0; i < PAL_ENTRIES; i++) begin
      apb(1'b0, ADDR_PAL + 12'(4 * i), 32'h0);
      chk(q, {23'h0, pal[i]});
    end
    mono_monitor_detect_n <= 1'b0;
    hsync_in <= 1'b1;
    vsync_in <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({28'h0, monitor_hsync, mod_hsync, monitor_vsync, mod_vsync}, 32'hf);
    chk({31'h0, irq_mono_detect}, 32'h1);
    hsync_in <= 1'b0;
    vsync_in <= 1'b0;
    latency <= 4'h6;
    line_active <= 1'b1;
    wait_hi(0);
    chk({8'h0, mem_addr}, b & 32'h00ffff00);
    wait_hi(1);
    @(posedge pclk);
    chk({31'h0, shifter_load_strobe}, 32'h1);
    wait_hi(0);
    chk({8'h0, mem_addr}, (b & 32'h00ffff00) + 32'h2);
    latency <= 4'h0;
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 3; k++) begin
        m = 4'($urandom);
        if (k == 0) m = 4'hf;
        if (r == 1) m[3:2] = m[1:0];
        apb(1'b1, ADDR_CTRL, 32'(r));
        run_line(m);
        repeat (8) begin
          @(posedge pclk);
          chk({23'h0, rgb_out}, exp_rgb(2'(r), m));
        end
      end
    end
    video_blanking <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({23'h0, rgb_out}, 32'h0);
    video_blanking <= 1'b0;
    apb(1'b1, ADDR_CTRL, {30'h0, RES_HIGH});
    for (int k = 0; k < 4; k++) begin
      m = {4{k[0]}};
      pal[0][0] = k[1];
      apb(1'b1, ADDR_PAL, {23'h0, pal[0]});
      run_line(m);
      chk({31'h0, mono_out}, {31'h0, m[0] ^ pal[0][0]});
      chk({23'h0, rgb_out}, 32'h0);
    end
    end_of_test();
  end
endmodule

`default_nettype wire
